// file: verilog/tes_pkg.sv
// Package with the register map, field layout and reset values of the trace enable start/stop bank.
package tes_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus geometry and register byte offsets.
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam logic [7:0]  OFF_SYS_CAP       = 8'h00;
    localparam logic [7:0]  OFF_SS_SELECT     = 8'h04;
    localparam logic [7:0]  OFF_TE_CTRL_ONE   = 8'h08;
    localparam logic [7:0]  OFF_TE_STATUS     = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int          CAP_PROC_LSB      = 12;
    localparam int          CAP_PROC_MSB      = 14;
    localparam int          CAP_STALL_BIT     = 8;
    localparam int          SS_START_LSB      = 0;
    localparam int          SS_START_MSB      = 7;
    localparam int          SS_STOP_LSB       = 16;
    localparam int          SS_STOP_MSB       = 23;
    localparam int          C1_RANGE_LSB      = 0;
    localparam int          C1_RANGE_MSB      = 3;
    localparam int          C1_EXCLUDE_BIT    = 24;
    localparam int          C1_SS_EN_BIT      = 25;
    localparam int          ST_ACTIVE_BIT     = 0;
    localparam int          ST_GATE_BIT       = 1;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Writable masks and reset values.
    localparam logic [31:0] SS_SELECT_MASK    = 32'h00FF00FF;
    localparam logic [31:0] SS_SELECT_RESET   = 32'h00000000;
    localparam logic [31:0] TE_CTRL_ONE_MASK  = 32'h0300000F;
    localparam logic [31:0] TE_CTRL_ONE_RESET = 32'h00000000;
    localparam logic [31:0] RD_ZERO           = 32'h00000000;
    localparam logic        STALL_SUPPORTED   = 1'h0;

endpackage : tes_pkg

// file: verilog/tes_field_reg.sv
// Masked software-writable register used for the select and control words.
`timescale 1ns/1ps
module tes_field_reg #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] MASK  = 32'hFFFFFFFF,
    parameter logic [31:0] RESET = 32'h00000000
) (
    input  wire logic             i_clk_sys,  // System clock.
    input  wire logic             i_resetn,   // Asynchronous reset, active low.
    input  wire logic             i_ce,       // Clock enable, freezes the word while low.
    input  wire logic             i_we,       // Write strobe for this word.
    input  wire logic [WIDTH-1:0] i_wdata,    // Write data.
    output logic      [WIDTH-1:0] o_q         // Stored word, reserved bits zero.
);

    localparam logic [WIDTH-1:0] MASK_W  = MASK[WIDTH-1:0];
    localparam logic [WIDTH-1:0] RESET_W = RESET[WIDTH-1:0] & MASK[WIDTH-1:0];

    // Only the implemented bits take a write; reserved bits stay zero.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_q <= RESET_W;
        end else if (i_ce && i_we) begin
            o_q <= i_wdata & MASK_W;
        end
    end

endmodule : tes_field_reg

// file: verilog/tes_top.sv
// Trace enable start/stop register bank with the trace gate qualifier logic.
`timescale 1ns/1ps
module tes_top
    import tes_pkg::*;
#(
    parameter int NUM_SINGLE = 8,
    parameter int NUM_RANGE  = 4
) (
    input  wire logic                  i_clk_sys,           // System clock, 20 MHz.
    input  wire logic                  i_resetn,            // Asynchronous reset, active low.
    input  wire logic                  i_ce,                // Clock enable, freezes all state while low.
    input  wire logic [ADDR_W-1:0]     i_addr,              // Register byte address.
    input  wire logic [DATA_W-1:0]     i_wdata,             // Write data.
    input  wire logic                  i_wr_en,             // Write strobe, one cycle.
    input  wire logic                  i_rd_en,             // Read strobe, one cycle.
    output logic      [DATA_W-1:0]     o_rdata,             // Read data, the cycle after the strobe.
    input  wire logic [2:0]            i_cfg_proc_count_m1, // Tied-off processor count minus one.
    input  wire logic [NUM_SINGLE-1:0] i_single_match,      // Single address comparator matches.
    input  wire logic [NUM_RANGE-1:0]  i_range_match,       // Address range comparator matches.
    output logic                       o_trace_active,      // Start/stop trace-active state.
    output logic                       o_trace_gate         // Qualified trace gate.
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when any selected comparator matches.
    function automatic logic sel_hit(input logic [7:0] match, input logic [7:0] sel);
        sel_hit = |(match & sel);
    endfunction : sel_hit

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    // One-hot decode of the register offsets.
    wire logic hit_cap    = (i_addr == OFF_SYS_CAP);
    wire logic hit_select = (i_addr == OFF_SS_SELECT);
    wire logic hit_ctrl   = (i_addr == OFF_TE_CTRL_ONE);
    wire logic hit_status = (i_addr == OFF_TE_STATUS);
    wire logic we_select  = i_wr_en && hit_select;
    wire logic we_ctrl    = i_wr_en && hit_ctrl;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Software registers.

    logic [DATA_W-1:0] start_stop_comparator_select;
    logic [DATA_W-1:0] trace_enable_control_one;

    // Start and stop comparator selection word.
    tes_field_reg #(
        .WIDTH (DATA_W),
        .MASK  (SS_SELECT_MASK),
        .RESET (SS_SELECT_RESET)
    ) u_select (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_we      (we_select),
        .i_wdata   (i_wdata),
        .o_q       (start_stop_comparator_select)
    );

    // Enable, mode and range selection word.
    tes_field_reg #(
        .WIDTH (DATA_W),
        .MASK  (TE_CTRL_ONE_MASK),
        .RESET (TE_CTRL_ONE_RESET)
    ) u_ctrl_one (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_we      (we_ctrl),
        .i_wdata   (i_wdata),
        .o_q       (trace_enable_control_one)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Field extraction.

    // Comparator selections and control bits pulled out of the words.
    wire logic [7:0] start_sel   = start_stop_comparator_select[SS_START_MSB:SS_START_LSB];
    wire logic [7:0] stop_sel    = start_stop_comparator_select[SS_STOP_MSB:SS_STOP_LSB];
    wire logic [3:0] range_sel   = trace_enable_control_one[C1_RANGE_MSB:C1_RANGE_LSB];
    wire logic       exclude     = trace_enable_control_one[C1_EXCLUDE_BIT];
    wire logic       ss_enable   = trace_enable_control_one[C1_SS_EN_BIT];

    // Comparator inputs widened to the common selector width.
    wire logic [7:0] single_m8   = 8'(i_single_match);
    wire logic [7:0] range_m8    = 8'(i_range_match);
    wire logic [7:0] range_sel8  = {4'h0, range_sel};

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Trace qualifier.

    // A stop in the same cycle as a start wins, so the region closes.
    wire logic start_hit   = sel_hit(single_m8, start_sel);
    wire logic stop_hit    = sel_hit(single_m8, stop_sel);
    wire logic next_active = stop_hit ? 1'b0 : (start_hit | o_trace_active);

    // Include mode traces only inside selected ranges; exclude mode traces outside them.
    wire logic range_hit   = sel_hit(range_m8, range_sel8);
    wire logic range_ok    = exclude ? !range_hit : range_hit;
    wire logic ss_ok       = !ss_enable || next_active;
    wire logic next_gate   = ss_ok && range_ok;

    // The active state tracks matches regardless of the enable bit.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_trace_active <= 1'b0;
            o_trace_gate   <= 1'b0;
        end else if (i_ce) begin
            o_trace_active <= next_active;
            o_trace_gate   <= next_gate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Capability word built from tie-off inputs; the stall bit is fixed at zero.
    logic [DATA_W-1:0] cap_word;
    always_comb begin
        cap_word                             = RD_ZERO;
        cap_word[CAP_PROC_MSB:CAP_PROC_LSB]  = i_cfg_proc_count_m1;
        cap_word[CAP_STALL_BIT]              = STALL_SUPPORTED;
    end

    // Status word showing the qualifier's own state.
    logic [DATA_W-1:0] status_word;
    always_comb begin
        status_word                = RD_ZERO;
        status_word[ST_ACTIVE_BIT] = o_trace_active;
        status_word[ST_GATE_BIT]   = o_trace_gate;
    end

    // Read selection; unmapped offsets read as zero.
    wire logic [DATA_W-1:0] next_rdata =
        hit_cap    ? cap_word                     :
        hit_select ? start_stop_comparator_select :
        hit_ctrl   ? trace_enable_control_one     :
        hit_status ? status_word                  : RD_ZERO;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= RD_ZERO;
        end else if (i_ce) begin
            o_rdata <= i_rd_en ? next_rdata : RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    // A capability read returns the tied-off processor count.
    property p_cap_proc;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && i_rd_en && hit_cap) |=> (o_rdata[CAP_PROC_MSB:CAP_PROC_LSB] == $past(i_cfg_proc_count_m1));
    endproperty
    a_cap_proc: assert property (p_cap_proc) else $error("capability count field wrong");

    // A capability read never shows stall support.
    property p_cap_stall;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && i_rd_en && hit_cap) |=> !o_rdata[CAP_STALL_BIT];
    endproperty
    a_cap_stall: assert property (p_cap_stall) else $error("stall bit reads one");

    // A write to the capability offset does not change what the following read returns.
    sequence s_cap_write_read;
        (i_ce && i_wr_en && hit_cap) ##1 (i_ce && i_rd_en && hit_cap);
    endsequence
    property p_cap_ro;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_cap_write_read |=> (o_rdata == (DATA_W'($past(i_cfg_proc_count_m1)) << CAP_PROC_LSB));
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capability changed by a write");

    // A selected stop comparator clears the active state next cycle.
    property p_stop;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && |(single_m8 & stop_sel)) |=> !o_trace_active;
    endproperty
    a_stop: assert property (p_stop) else $error("stop match did not clear active");

    // A selected start with no stop sets the active state next cycle.
    sequence s_start_only;
        i_ce && |(single_m8 & start_sel) && !(|(single_m8 & stop_sel));
    endsequence
    property p_start;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_start_only |=> o_trace_active;
    endproperty
    a_start: assert property (p_start) else $error("start match did not set active");

    // Without any match the active state holds.
    property p_hold;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && !(|(single_m8 & (start_sel | stop_sel)))) |=> (o_trace_active == $past(o_trace_active));
    endproperty
    a_hold: assert property (p_hold) else $error("active changed without a match");

    // With start/stop disabled and exclude mode outside every range, the gate opens.
    property p_ss_off;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && !ss_enable && exclude && !(|(range_m8 & range_sel8))) |=> o_trace_gate;
    endproperty
    a_ss_off: assert property (p_ss_off) else $error("gate closed with qualifier off");

    // With start/stop enabled and the region closed, the gate stays shut.
    property p_ss_on;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && ss_enable && !next_active) |=> !o_trace_gate;
    endproperty
    a_ss_on: assert property (p_ss_on) else $error("gate open outside start/stop region");

    // Include mode closes the gate outside the selected ranges.
    property p_include;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && !exclude && !(|(range_m8 & range_sel8))) |=> !o_trace_gate;
    endproperty
    a_include: assert property (p_include) else $error("include mode traced outside range");

    // Exclude mode closes the gate inside a selected range.
    property p_exclude;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && exclude && |(range_m8 & range_sel8)) |=> !o_trace_gate;
    endproperty
    a_exclude: assert property (p_exclude) else $error("exclude mode traced inside range");

    // A control write reads back masked on the next read.
    sequence s_ctrl_write_read;
        (i_ce && we_ctrl) ##1 (i_ce && i_rd_en && hit_ctrl && !i_wr_en);
    endsequence
    property p_ctrl_rw;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_ctrl_write_read |=> (o_rdata == ($past(i_wdata, 2) & TE_CTRL_ONE_MASK));
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw) else $error("control word readback wrong");

    // A select write reads back masked on the next read.
    sequence s_sel_write_read;
        (i_ce && we_select) ##1 (i_ce && i_rd_en && hit_select && !i_wr_en);
    endsequence
    property p_sel_rw;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_sel_write_read |=> (o_rdata == ($past(i_wdata, 2) & SS_SELECT_MASK));
    endproperty
    a_sel_rw: assert property (p_sel_rw) else $error("select word readback wrong");

    // Every capability bit outside the processor field reads zero, the stall bit included.
    property p_cap_zero;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && i_rd_en && hit_cap)
            |=> ((o_rdata[DATA_W-1:CAP_PROC_MSB+1] == '0) && (o_rdata[CAP_PROC_LSB-1:0] == '0));
    endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("capability reserved bits not zero");

    // Reserved bits of the control word always read zero.
    property p_ctrl_zero;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && i_rd_en && hit_ctrl) |=> ((o_rdata & ~TE_CTRL_ONE_MASK) == RD_ZERO);
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control reserved bits not zero");

    // With start/stop disabled, include mode inside a selected range opens the gate.
    property p_ss_off_inside;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && !ss_enable && !exclude && |(range_m8 & range_sel8)) |=> o_trace_gate;
    endproperty
    a_ss_off_inside: assert property (p_ss_off_inside) else $error("gate closed inside included range");

    // With start/stop enabled, a lone start match outside every excluded range opens the gate.
    property p_ss_on_open;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && ss_enable && exclude && !(|(range_m8 & range_sel8))
            && |(single_m8 & start_sel) && !(|(single_m8 & stop_sel))) |=> o_trace_gate;
    endproperty
    a_ss_on_open: assert property (p_ss_on_open) else $error("gate shut after start match");

    // An opened region stays open while no selected comparator matches.
    sequence s_quiet;
        i_ce && !(|(single_m8 & (start_sel | stop_sel)));
    endsequence
    property p_stay_open;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_start_only ##1 s_quiet |=> o_trace_active;
    endproperty
    a_stay_open: assert property (p_stay_open) else $error("region closed without a stop");

    // A closed region stays closed while no selected comparator matches.
    property p_stay_closed;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && |(single_m8 & stop_sel)) ##1 s_quiet |=> !o_trace_active;
    endproperty
    a_stay_closed: assert property (p_stay_closed) else $error("region opened without a start");

    // A status read shows the active state and the gate as they stood at the strobe.
    property p_status;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_ce && i_rd_en && hit_status)
            |=> ((o_rdata[ST_ACTIVE_BIT] == $past(o_trace_active)) && (o_rdata[ST_GATE_BIT] == $past(o_trace_gate)));
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");

    // A low clock enable freezes every output.
    property p_freeze;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (!i_ce) |=> ($stable(o_trace_active) && $stable(o_trace_gate) && $stable(o_rdata));
    endproperty
    a_freeze: assert property (p_freeze) else $error("output moved with clock enable low");

endmodule : tes_top

// file: dv/tes_core_model.sv
// Behavioural stand-in for the traced core that drives the comparator match lines.
`timescale 1ns/1ps
module tes_core_model (
    input  wire logic       i_clk_sys,      // System clock.
    input  wire logic       i_resetn,       // Asynchronous reset, active low.
    input  wire logic [7:0] i_single_req,   // Single comparator hits to present next cycle.
    input  wire logic [3:0] i_range_req,    // Range comparator hits to present next cycle.
    output logic      [7:0] o_single_match, // Single comparator match lines.
    output logic      [3:0] o_range_match   // Range comparator match lines.
);
    // The core's comparators are registered, so a hit shows one cycle after it is requested.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_single_match <= 8'h00;
            o_range_match  <= 4'h0;
        end else begin
            o_single_match <= i_single_req;
            o_range_match  <= i_range_req;
        end
    end
endmodule : tes_core_model

// file: dv/trace_enable_start_stop_config_test.sv
// Self-checking bench for the trace enable start/stop register bank.
`timescale 1ns/1ps
module trace_enable_start_stop_config_test;
    import tes_pkg::*;
    logic        clk_sys = 1'b0;
    logic        resetn, ce, wr_en, rd_en, act, gate;
    logic [7:0]  addr, s_req, s_m;
    logic [3:0]  r_req, r_m;
    logic [2:0]  cfg;
    logic [31:0] wdata, rdata;
    int          mismatches = 0;
    int          n_tests    = 0;
    int          cycles     = 0;
    int          m_sel, m_c1, m_act, m_gate, m_rd;

    // Free-running 20 MHz system clock.
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    tes_top u_tes_top (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata), .i_cfg_proc_count_m1(cfg), .i_single_match(s_m),
        .i_range_match(r_m), .o_trace_active(act), .o_trace_gate(gate));
    tes_core_model u_tes_core_model (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_single_req(s_req),
        .i_range_req(r_req), .o_single_match(s_m), .o_range_match(r_m));

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Compares one value, counting every call and every difference.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // One bus cycle launched just after a rising edge; strobes last until the next call.
    task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_en <= w;
        rd_en <= r;
        addr  <= a;
        wdata <= d;
    endtask : drive

    // Read value the model expects for an address, taken before this edge's updates.
    function automatic int rdval(input logic [7:0] a);
        case (a)
            OFF_SYS_CAP:     return int'(cfg) << CAP_PROC_LSB;
            OFF_SS_SELECT:   return m_sel;
            OFF_TE_CTRL_ONE: return m_c1;
            OFF_TE_STATUS:   return (m_gate << 1) | m_act;
            default:         return 0;
        endcase
    endfunction : rdval

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Reference model of the bank, updated on the same edges as the design.
    always @(posedge clk_sys or negedge resetn) begin : model
        int sh, ph, rh, na;
        if (!resetn) begin
            m_sel  = 0;
            m_c1   = 0;
            m_act  = 0;
            m_gate = 0;
            m_rd   = 0;
        end else if (ce) begin
            sh     = |(s_m & m_sel[7:0]);
            ph     = |(s_m & m_sel[23:16]);
            rh     = |(r_m & m_c1[3:0]);
            na     = ph ? 0 : (sh | m_act);
            m_rd   = rd_en ? rdval(addr) : 0;
            m_gate = (!m_c1[25] || na) && (m_c1[24] ? !rh : rh);
            m_act  = na;
            if (wr_en && addr == OFF_SS_SELECT) m_sel = wdata & 32'h00FF00FF;
            if (wr_en && addr == OFF_TE_CTRL_ONE) m_c1 = wdata & 32'h0300000F;
        end
    end

    // Compares every output once per cycle where it has settled, and cuts a hang short.
    always @(negedge clk_sys) begin
        cycles++;
        if (resetn) begin
            check("trace_active", {31'h0, act}, m_act);
            check("trace_gate", {31'h0, gate}, m_gate);
            check("rdata", rdata, m_rd);
        end
        if (cycles > 6000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, masking, tie-off inputs, start/stop order, random traffic.
    initial begin : main
        int         i;
        logic [7:0] seq [5];
        resetn = 1'b0;
        ce     = 1'b1;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        addr   = 8'h00;
        wdata  = 32'h00000000;
        cfg    = 3'h0;
        s_req  = 8'h00;
        r_req  = 4'h0;
        seq    = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h01};
        void'($urandom(64));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 5; i++) drive(1'b0, 1'b1, 8'(i * 4), 32'h0);
        for (i = 0; i < 5; i++) drive(1'b1, 1'b0, 8'(i * 4), 32'hFFFFFFFF);
        for (i = 0; i < 5; i++) drive(1'b0, 1'b1, 8'(i * 4), 32'h0);
        for (i = 0; i < 8; i++) begin
            drive(1'b0, 1'b1, OFF_SYS_CAP, 32'h0);
            cfg <= i[2:0];
        end
        cfg <= 3'h0;
        drive(1'b1, 1'b0, OFF_SS_SELECT, 32'h00020001);
        drive(1'b1, 1'b0, OFF_TE_CTRL_ONE, 32'h03000000);
        for (i = 0; i < 5; i++) begin
            drive(1'b0, 1'b1, OFF_TE_STATUS, 32'h0);
            s_req <= seq[i];
            drive(1'b0, 1'b0, 8'h00, 32'h0);
        end
        repeat (4000) begin
            @(posedge clk_sys);
            i = $urandom % 3;
            wr_en <= (i == 1);
            rd_en <= (i == 2);
            addr  <= 8'($urandom_range(4, 0) * 4);
            wdata <= $urandom;
            ce    <= ($urandom % 8) != 0;
            s_req <= 8'($urandom);
            r_req <= 4'($urandom);
        end
        ce <= 1'b1;
        drive(1'b0, 1'b0, 8'h00, 32'h0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 5; i++) drive(1'b0, 1'b1, 8'(i * 4), 32'h0);
        drive(1'b0, 1'b0, 8'h00, 32'h0);
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule : trace_enable_start_stop_config_test
